// ---- core/eiu_pkg.sv ----
/*
  constants shared by the external pin interrupt unit: register offsets,
  bit positions, reset values, sense encodings and vector numbers.
  assumes a 32-bit apb slave with one register per aligned word.
*/
package eiu_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] EIU_ADDR_MCU_CTRL = 8'h00;
  localparam logic [7:0] EIU_ADDR_MCU_CSR = 8'h04;
  localparam logic [7:0] EIU_ADDR_GICTRL = 8'h08;
  localparam logic [7:0] EIU_ADDR_GIFLAG = 8'h0C;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] EIU_RST_MCU_CTRL = 8'h00;
  localparam logic [7:0] EIU_RST_MCU_CSR = 8'h00;
  localparam logic [7:0] EIU_RST_GICTRL = 8'h00;
  localparam logic [2:0] EIU_RST_FLAGS = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned EIU_SNS1_LSB = 2; // line one sense, bits 3:2
  localparam int unsigned EIU_SNS0_LSB = 0; // line zero sense, bits 1:0
  localparam int unsigned EIU_POL2_BIT = 6; // line two edge polarity
  localparam int unsigned EIU_L1_BIT = 7; // enable and flag of line one
  localparam int unsigned EIU_L0_BIT = 6; // enable and flag of line zero
  localparam int unsigned EIU_L2_BIT = 5; // enable and flag of line two

  // ----------------------------------------------------------------
  // sense encodings and vectors
  // ----------------------------------------------------------------
  localparam logic [1:0] EIU_SNS_LOW = 2'h0;
  localparam logic [1:0] EIU_SNS_ANY = 2'h1;
  localparam logic [1:0] EIU_SNS_FALL = 2'h2;
  localparam logic [1:0] EIU_SNS_RISE = 2'h3;
  localparam logic [1:0] EIU_VEC_NONE = 2'h0;
  localparam logic [1:0] EIU_VEC_L0 = 2'h1;
  localparam logic [1:0] EIU_VEC_L1 = 2'h2;
  localparam logic [1:0] EIU_VEC_L2 = 2'h3;

  // ----------------------------------------------------------------
  // line two minimum pulse width, for reference by the bench
  // ----------------------------------------------------------------
  localparam int unsigned EIU_L2_MIN_PULSE_NS = 50;

endpackage

// ---- core/eiu_edge_cap.sv ----
/*
  clockless edge catcher for request line two: every selected edge on the
  pin flips a toggle that the pclk side synchronises.
  assumes the pin is glitch free above the minimum pulse width.
*/
module eiu_edge_cap
  import eiu_pkg::*;
(
  input wire logic pin, // line two level after the input buffer
  input wire logic polarity, // 1 rising, 0 falling
  input wire logic rst_n, // asynchronous reset, active low
  output logic evt_tog_q // flips once per captured edge
);

  logic cap_clk;

  // the pin itself clocks the catcher; polarity picks the edge
  assign cap_clk = polarity ? pin : ~pin;

  // toggle on each captured edge
  always_ff @(posedge cap_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_tog_q <= 1'b0;
    end else begin
      evt_tog_q <= ~evt_tog_q;
    end
  end

endmodule

// ---- core/eiu_top.sv ----
/*
  external pin interrupt unit: three request lines, sense control, enable
  masks, pending flags, request and vector to the core, apb registers.
  assumes the core drives its global enable bit and pulses an acknowledge
  when it enters the presented vector; pins are synchronous to pclk
  except line two, which is caught without the clock.
*/
// How it works
// - line one sense bits 3:2: low, any change, falling, rising.
// - line zero sense bits 1:0 use the same four codes.
// - request reaches the core only with global enable and line enable.
// - lines zero and one are clocked in before edges are looked for.
// - line two edge only; bit 6 picks falling (0) or rising (1).
// - line two edges are caught without the clock.
// - enables sit at bits 7, 6, 5 for lines one, zero, two.
// - pin activity counts even when the pin is driven by this chip.
// - each line has its own vector.
// - a triggering event sets flag bit 7, 6 or 5.
// - flag clears on vector entry or on writing one; zero does nothing.
// - flags of lines zero and one read zero in low level mode.
// - sleeping with line two disabled gates its buffer, may set its flag.
// - low level request stays asserted while the pin stays low.
// - low level needs no edge history; line two toggles are flagged by clocked change detection.
module eiu_top
  import eiu_pkg::*;
(
  input wire logic pclk, // bus and unit clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, 1 write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_request_line_zero, // pin of line zero
  input wire logic ext_request_line_one, // pin of line one
  input wire logic ext_request_line_two, // pin of line two
  input wire logic global_irq_en, // global enable bit of the core
  input wire logic irq_ack, // pulse: core enters presented vector
  input wire logic sleep_deep, // core sits in a buffer-gating sleep
  output logic irq_req, // request to the core
  output logic [1:0] irq_vector // vector of the presented request
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0] mcu_control_q;
  logic [7:0] mcu_csr_q;
  logic [7:0] gictrl_q;
  logic [2:0] flag_q, flag_d; // index 0, 1, 2 = line zero, one, two
  logic [2:0] sy0_q, sy1_q, sy2_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_req_q;
  logic [1:0] irq_vector_q;

  // sense decode shared by lines zero and one
  function automatic logic sense_hit(input logic [1:0] sns,
                                     input logic prev, input logic cur);
    case (sns)
      EIU_SNS_ANY: sense_hit = prev ^ cur;
      EIU_SNS_FALL: sense_hit = prev & ~cur;
      EIU_SNS_RISE: sense_hit = ~prev & cur;
      default: sense_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire [1:0] sns0 = mcu_control_q[EIU_SNS0_LSB +: 2];
  wire [1:0] sns1 = mcu_control_q[EIU_SNS1_LSB +: 2];
  wire pol2 = mcu_csr_q[EIU_POL2_BIT];
  wire [2:0] en = {gictrl_q[EIU_L2_BIT], gictrl_q[EIU_L1_BIT],
                   gictrl_q[EIU_L0_BIT]};
  wire lvl0 = (sns0 == EIU_SNS_LOW);
  wire lvl1 = (sns1 == EIU_SNS_LOW);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire hit_ctrl = (paddr == EIU_ADDR_MCU_CTRL);
  wire hit_csr = (paddr == EIU_ADDR_MCU_CSR);
  wire hit_gic = (paddr == EIU_ADDR_GICTRL);
  wire hit_gif = (paddr == EIU_ADDR_GIFLAG);
  wire addr_ok = hit_ctrl | hit_csr | hit_gic | hit_gif;
  wire wr_go = psel & penable & pready_q & pwrite & addr_ok;
  wire [7:0] wb = pwdata[7:0];

  // level mode flags read as zero
  wire [7:0] flag_rd = (8'h01 << EIU_L1_BIT) & {8{flag_q[1] & ~lvl1}}
                     | (8'h01 << EIU_L0_BIT) & {8{flag_q[0] & ~lvl0}}
                     | (8'h01 << EIU_L2_BIT) & {8{flag_q[2]}};
  wire [7:0] rd_mux = hit_ctrl ? mcu_control_q :
                      hit_csr ? mcu_csr_q :
                      hit_gic ? gictrl_q :
                      hit_gif ? flag_rd : 8'h00;

  // bus answer: one access cycle, data loaded in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_ok;
      if (setup && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // control registers; only polarity bit of the status word is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_control_q <= EIU_RST_MCU_CTRL;
      mcu_csr_q <= EIU_RST_MCU_CSR;
      gictrl_q <= EIU_RST_GICTRL;
    end else if (wr_go) begin
      if (hit_ctrl) mcu_control_q <= wb;
      if (hit_csr) mcu_csr_q <= wb & (8'h01 << EIU_POL2_BIT);
      if (hit_gic) gictrl_q <= wb & ((8'h01 << EIU_L1_BIT)
                 | (8'h01 << EIU_L0_BIT) | (8'h01 << EIU_L2_BIT));
    end
  end

  // ----------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------
  // buffer gated in deep sleep with line two disabled
  wire pin2_eff = ext_request_line_two & ~(sleep_deep & ~en[2]);
  logic tog2;

  eiu_edge_cap u_cap2 (
    .pin(pin2_eff),
    .polarity(pol2),
    .rst_n(presetn),
    .evt_tog_q(tog2)
  );

  // two stage synchronisers plus one history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy0_q <= 3'h7;
      sy1_q <= 3'h7;
      sy2_q <= 3'h0;
    end else begin
      // pin levels are read whatever drives them
      sy0_q <= {sy0_q[1:0], ext_request_line_zero};
      sy1_q <= {sy1_q[1:0], ext_request_line_one};
      sy2_q <= {sy2_q[1:0], tog2};
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  // edges from successive synchronised samples
  wire [2:0] set = {sy2_q[2] ^ sy2_q[1],
                    sense_hit(sns1, sy1_q[2], sy1_q[1]),
                    sense_hit(sns0, sy0_q[2], sy0_q[1])};
  wire [2:0] clr_w = {3{wr_go & hit_gif}} &
                     {wb[EIU_L2_BIT], wb[EIU_L1_BIT], wb[EIU_L0_BIT]};
  wire [2:0] clr_a = {3{irq_ack}} & {irq_vector_q == EIU_VEC_L2,
                     irq_vector_q == EIU_VEC_L1,
                     irq_vector_q == EIU_VEC_L0};

  // set wins over a clear in the same cycle
  // clear on vector entry or written one
  // flags held clear in level mode
  always_comb begin
    flag_d = set | (flag_q & ~(clr_w | clr_a));
    if (lvl0) flag_d[0] = 1'b0;
    if (lvl1) flag_d[1] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= EIU_RST_FLAGS;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ----------------------------------------------------------------
  // request and vector
  // ----------------------------------------------------------------
  // level mode requests while the pin is low
  // level path needs no edge history
  wire [2:0] pend = {flag_q[2],
                     lvl1 ? ~sy1_q[1] : flag_q[1],
                     lvl0 ? ~sy0_q[1] : flag_q[0]};
  wire [2:0] act = pend & en & {3{global_irq_en}};
  wire [1:0] vec_d = act[0] ? EIU_VEC_L0 :
                     act[1] ? EIU_VEC_L1 :
                     act[2] ? EIU_VEC_L2 : EIU_VEC_NONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= EIU_VEC_NONE;
    end else begin
      irq_req_q <= |act;
      irq_vector_q <= vec_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_req = irq_req_q;
  assign irq_vector = irq_vector_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lvl_flag_zero_a: assert property (
    (lvl0 |-> !flag_rd[EIU_L0_BIT]) and (lvl1 |-> !flag_rd[EIU_L1_BIT]))
    else $error("level mode flag reads set");

  rise_one_a: assert property (
    (sns1 == EIU_SNS_RISE) && $rose(ext_request_line_one)
    |=> ##2 flag_q[1])
    else $error("line one rising edge lost");

  fall_zero_a: assert property (
    (sns0 == EIU_SNS_FALL) && $fell(ext_request_line_zero)
    && (sns0 == EIU_SNS_FALL) [*1] |=> ##2 (flag_q[0] || lvl0))
    else $error("line zero falling edge lost");

  gate_global_a: assert property (
    !global_irq_en || en == 3'h0 |=> !irq_req_q)
    else $error("request without enables");

  sync_two_a: assert property (
    ##2 sy0_q[1] == $past(ext_request_line_zero, 2))
    else $error("line zero synchroniser depth wrong");

  w1c_clear_a: assert property (
    wr_go && hit_gif && wb[EIU_L2_BIT] && !set[2] |=> !flag_q[2])
    else $error("write one did not clear flag");

  w0_keep_a: assert property (
    flag_q[2] && wr_go && hit_gif && !wb[EIU_L2_BIT] && !clr_a[2]
    |=> flag_q[2])
    else $error("write zero cleared flag");

  level_hold_a: assert property (
    lvl0 && !sy0_q[1] && en[0] && global_irq_en
    |=> irq_req_q && irq_vector_q == EIU_VEC_L0)
    else $error("low level request missing");

  two_edge_a: assert property (
    sy2_q[2] != sy2_q[1] |=> flag_q[2])
    else $error("line two edge did not set flag");

  vec_own_a: assert property (
    irq_req_q && irq_vector_q == EIU_VEC_L2 |-> $past(!act[0] && !act[1]))
    else $error("line two vector over higher line");

  any_one_a: assert property (
    (sns1 == EIU_SNS_ANY) && $changed(ext_request_line_one)
    |=> ##2 flag_q[1])
    else $error("line one change lost");

  any_zero_a: assert property (
    (sns0 == EIU_SNS_ANY) && $changed(ext_request_line_zero)
    |=> ##2 flag_q[0])
    else $error("line zero change lost");

  req_global_a: assert property (
    irq_req_q |-> $past(global_irq_en))
    else $error("request while globally masked");

  req_line_a: assert property (
    irq_req_q && irq_vector_q == EIU_VEC_L1 |-> $past(en[1]))
    else $error("line one request while masked");

  ack_clear_a: assert property (
    irq_ack && irq_vector_q == EIU_VEC_L1 && !set[1] |=> !flag_q[1])
    else $error("vector entry left flag set");

  sleep_gate_a: assert property (
    sleep_deep && !en[2] |-> !pin2_eff)
    else $error("line two buffer not gated");

  vec_first_a: assert property (
    act[0] |=> irq_req_q && irq_vector_q == EIU_VEC_L0)
    else $error("line zero not presented first");

endmodule

// ---- verification/eiu_pin_src.sv ----
/*
  pin sources for the external pin interrupt unit.
  assumes pins idle high, as behind a pull-up.
*/
module eiu_pin_src
  import eiu_pkg::*;
(
  input wire logic pclk, // unit clock, paces lines zero and one
  output logic pin0, // line zero pin
  output logic pin1, // line one pin
  output logic pin2 // line two pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle high
  initial begin
    pin0 = 1'b1;
    pin1 = 1'b1;
    pin2 = 1'b1;
  end

  task automatic set01(input logic l, input logic v);
    @(posedge pclk);
    if (l) pin1 <= v;
    else pin0 <= v;
  endtask

  // pulse above minimum width, unaligned to pclk
  task automatic pulse2();
    #13;
    pin2 = 1'b0;
    #(EIU_L2_MIN_PULSE_NS + 10);
    pin2 = 1'b1;
  endtask
endmodule

// ---- verification/tb_top.sv ----
/*
  self-checking bench for the external pin interrupt unit.
  assumes zero wait state apb and the core side played by this bench.
*/
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top
  import eiu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pin0, pin1, pin2, gie, ack, sleep_deep, irq_req, req_d;
  logic [1:0] irq_vector;
  logic [32:0] rq[$];
  logic [1:0] vq[$];
  int failures = 0;
  int checks = 0;
  int r;
  logic [32:0] exp_rd;
  logic [1:0] exp_vec;

  eiu_top i_eiu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_request_line_zero(pin0), .ext_request_line_one(pin1),
    .ext_request_line_two(pin2), .global_irq_en(gie), .irq_ack(ack),
    .sleep_deep(sleep_deep), .irq_req(irq_req), .irq_vector(irq_vector));
  eiu_pin_src i_eiu_pin_src (.pclk(pclk), .pin0(pin0), .pin1(pin1),
    .pin2(pin2));

  // ----------------------------------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #800000;
    failures++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // apb master and core side
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; the watchdog ends it if pready never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back({a > EIU_ADDR_GIFLAG, x});
    apb(1'b0, a, 32'h0);
  endtask

  // wait for a request, then enter its vector
  task automatic take_irq();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irq_req !== 1'b1 && n < 20);
    if (irq_req !== 1'b1) begin
      failures++;
      print_verdict();
    end
    @(posedge pclk);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ready, read data and request vectors against the oldest notes
  always @(posedge pclk) begin
    if (psel && penable) `CHK(pready, 1'b1)
    if (psel && penable && pready && !pwrite) begin
      exp_rd = rq.pop_front();
      `CHK({pslverr, prdata}, exp_rd)
    end
    if (irq_req && !req_d) begin
      exp_vec = vq.pop_front();
      `CHK(irq_vector, exp_vec)
    end
    req_d <= irq_req;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, gie, ack, sleep_deep} = '0;
    presetn = 1'b0;
    r = $urandom(32'h459caa31);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, then an unmapped word
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
    // random contents, masked by field
    repeat (4) begin
      r = $urandom;
      apb(1'b1, EIU_ADDR_MCU_CTRL, r);
      rd(EIU_ADDR_MCU_CTRL, 32'(r[7:0]));
      apb(1'b1, EIU_ADDR_MCU_CSR, r);
      rd(EIU_ADDR_MCU_CSR, 32'(r[7:0] & 8'h40));
      apb(1'b1, EIU_ADDR_GICTRL, r);
      rd(EIU_ADDR_GICTRL, 32'(r[7:0] & 8'hE0));
    end
    apb(1'b1, EIU_ADDR_GICTRL, 32'h0);
    apb(1'b1, EIU_ADDR_MCU_CSR, 32'h0);
    // each edge sense on lines zero and one
    for (int l = 0; l < 2; l++) begin
      for (int m = 1; m < 4; m++) begin
        apb(1'b1, EIU_ADDR_MCU_CTRL, 32'(m << (l * 2)));
        apb(1'b1, EIU_ADDR_GIFLAG, 32'hFF);
        i_eiu_pin_src.set01(l[0], 1'b0);
        repeat (6) @(posedge pclk);
        apb(1'b1, EIU_ADDR_GIFLAG, 32'h0);
        rd(EIU_ADDR_GIFLAG, (m != 3) ? (32'h40 << l) : 32'h0);
        apb(1'b1, EIU_ADDR_GIFLAG, 32'hFF);
        i_eiu_pin_src.set01(l[0], 1'b1);
        repeat (6) @(posedge pclk);
        rd(EIU_ADDR_GIFLAG, (m != 2) ? (32'h40 << l) : 32'h0);
      end
    end
    // low level on line zero
    apb(1'b1, EIU_ADDR_MCU_CTRL, 32'h0);
    i_eiu_pin_src.set01(1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    rd(EIU_ADDR_GIFLAG, 32'h0);
    gie <= 1'b1;
    vq.push_back(EIU_VEC_L0);
    apb(1'b1, EIU_ADDR_GICTRL, 32'h40);
    repeat (6) @(posedge pclk);
    repeat (8) @(posedge pclk) `CHK(irq_req, 1'b1)
    i_eiu_pin_src.set01(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    // line one falling edge held back by the global enable
    apb(1'b1, EIU_ADDR_MCU_CTRL, 32'(EIU_SNS_FALL) << EIU_SNS1_LSB);
    gie <= 1'b0;
    apb(1'b1, EIU_ADDR_GICTRL, 32'h80);
    apb(1'b1, EIU_ADDR_GIFLAG, 32'hFF);
    i_eiu_pin_src.set01(1'b1, 1'b0);
    repeat (8) @(posedge pclk);
    `CHK(irq_req, 1'b0)
    vq.push_back(EIU_VEC_L1);
    gie <= 1'b1;
    take_irq();
    rd(EIU_ADDR_GIFLAG, 32'h0);
    i_eiu_pin_src.set01(1'b1, 1'b1);
    // line two both polarities, safe change sequence
    // mask, repolarise, settle, clear
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, EIU_ADDR_GICTRL, 32'h0);
      apb(1'b1, EIU_ADDR_MCU_CSR, 32'(p << EIU_POL2_BIT));
      // let a polarity edge pass the synchroniser before clearing
      repeat (4) @(posedge pclk);
      apb(1'b1, EIU_ADDR_GIFLAG, 32'hFF);
      apb(1'b1, EIU_ADDR_GICTRL, 32'h20);
      vq.push_back(EIU_VEC_L2);
      i_eiu_pin_src.pulse2();
      take_irq();
      rd(EIU_ADDR_GIFLAG, 32'h0);
    end
    // gated buffer in sleep with line two disabled
    apb(1'b1, EIU_ADDR_GICTRL, 32'h0);
    apb(1'b1, EIU_ADDR_MCU_CSR, 32'h0);
    apb(1'b1, EIU_ADDR_GIFLAG, 32'hFF);
    sleep_deep <= 1'b1;
    repeat (8) @(posedge pclk);
    sleep_deep <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(EIU_ADDR_GIFLAG, 32'h20);
    apb(1'b1, EIU_ADDR_GIFLAG, 32'h0);
    rd(EIU_ADDR_GIFLAG, 32'h20);
    apb(1'b1, EIU_ADDR_GIFLAG, 32'h20);
    rd(EIU_ADDR_GIFLAG, 32'h0);
    print_verdict();
  end
endmodule
